/* core/pwc_pkg.sv */
package pwc_pkg;
    localparam int          NUM_CH        = 4;
    localparam int          DATA_W        = 8;
    localparam int          PRESC_W       = 7;
    localparam int          ADDR_W        = 16;
    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_CLKSEL    = 14'h1060;
    localparam logic [13:0] IDX_SRCLVL    = 14'h1061;
    localparam logic [13:0] IDX_SCALE     = 14'h1062;
    localparam logic [13:0] IDX_ENABLE    = 14'h1063;
    localparam logic [13:0] IDX_CNT0      = 14'h1064;
    localparam logic [13:0] IDX_PER0      = 14'h1068;
    localparam logic [13:0] IDX_DTY0      = 14'h106C;
    localparam logic [13:0] IDX_TEST      = 14'h1070;
    // pwm_clock_prescale_select fields
    localparam int          CLK_RATE_A_LO = 0;
    localparam int          CLK_RATE_B_LO = 3;
    localparam int          CLK_JOIN_LOW  = 6;
    localparam int          CLK_JOIN_HIGH = 7;
    // pwm_clock_source_and_level fields
    localparam int          SRC_LEVEL_LO  = 0;
    localparam int          SRC_SEL_LO    = 4;
    // factory_test_register fields
    localparam int          TEST_MODE_BIT = 0;
    localparam int          TEST_READ_BIT = 1;
    // Reset values, prescaler mask and unmapped read data
    localparam logic [7:0]  RST_CTRL      = 8'h00;
    localparam logic [7:0]  RST_PER_DTY   = 8'hFF;
    localparam logic [7:0]  RST_COUNT     = 8'h00;
    localparam logic [6:0]  PRESC_ONES    = 7'h7F;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

/* core/pwc_core.sv */
`timescale 1ns/10ps
`default_nettype none
module pwc_core (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_b,
    input  wire logic                       sysClkEn,
    input  wire logic [pwc_pkg::ADDR_W-1:0] avsAddress,
    input  wire logic                       avsRead,
    input  wire logic                       avsWrite,
    input  wire logic [31:0]                avsWritedata,
    input  wire logic [3:0]                 avsByteenable,
    output logic      [31:0]                avsReaddata,
    output logic                            avsWaitrequest,
    input  wire logic [pwc_pkg::NUM_CH-1:0] gpioData,
    input  wire logic [pwc_pkg::NUM_CH-1:0] gpioDir,
    output logic      [pwc_pkg::NUM_CH-1:0] pinOut,
    output logic      [pwc_pkg::NUM_CH-1:0] pinOe
);
    import pwc_pkg::*;

    // Bus and software register state
    logic        ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0]  clkSel_reg, clkSel_next;
    logic [7:0]  srcLvl_reg, srcLvl_next;
    logic [7:0]  scale_reg, scale_next;
    logic [7:0]  enable_reg, enable_next;
    logic [7:0]  test_reg, test_next;
    logic [7:0]  per_reg [NUM_CH];
    logic [7:0]  per_next [NUM_CH];
    logic [7:0]  dty_reg [NUM_CH];
    logic [7:0]  dty_next [NUM_CH];
    // Clock generation state
    logic [PRESC_W-1:0] presc_reg, presc_next;
    logic [7:0]  sCnt_reg, sCnt_next;
    logic        sHalf_reg, sHalf_next;
    // Channel state
    logic [7:0]  cnt_reg [NUM_CH];
    logic [7:0]  cnt_next [NUM_CH];
    logic [7:0]  perBuf_reg [NUM_CH];
    logic [7:0]  perBuf_next [NUM_CH];
    logic [7:0]  dtyBuf_reg [NUM_CH];
    logic [7:0]  dtyBuf_next [NUM_CH];
    logic [NUM_CH-1:0] run_reg, run_next;
    logic [NUM_CH-1:0] wave_reg, wave_next;

    logic [13:0]        idx;
    logic               wrEn;
    logic               rdEn;
    logic [NUM_CH-1:0]  wrCnt;
    logic [NUM_CH-1:0]  chTick;
    logic [PRESC_W-1:0] maskA, maskB;
    logic               tickA, tickB, tickS, sWrap;

    assign idx            = avsAddress[ADDR_W-1:2];
    // Writes land only at the completion edge, where waitrequest is sampled low
    assign wrEn           = avsWrite & ack_reg & avsByteenable[0];
    assign rdEn           = avsRead & ~ack_reg;
    // One wait state on every access keeps read data registered
    assign avsWaitrequest = (avsRead | avsWrite) & ~ack_reg;
    assign avsReaddata    = rdata_reg;

    // Clock A, B prescaler; a single free-running counter keeps the two in phase
    assign maskA = ~(PRESC_ONES << clkSel_reg[CLK_RATE_A_LO +: 2]);
    assign maskB = ~(PRESC_ONES << clkSel_reg[CLK_RATE_B_LO +: 3]);
    assign tickA = &(presc_reg | ~maskA);
    assign tickB = &(presc_reg | ~maskB);
    // Divisor minus one wraps zero to 255, so zero counts 256 ticks
    assign sWrap = (sCnt_reg == scale_reg - 8'h01);
    assign tickS = tickA & sWrap & sHalf_reg;

    // Select bits act at once; a pulse may be cut short on a switch
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (srcLvl_reg[SRC_SEL_LO + i]) begin
                chTick[i] = tickS;
            end else if (i < 2) begin
                chTick[i] = tickA;
            end else begin
                chTick[i] = tickB;
            end
        end
    end

    always_comb begin
        presc_next = presc_reg + 7'h01;
        sCnt_next  = sCnt_reg;
        sHalf_next = sHalf_reg;
        if (wrEn && idx == IDX_SCALE) begin
            sCnt_next  = 8'h00;
            sHalf_next = 1'b0;
        end else if (tickA) begin
            sCnt_next = sWrap ? 8'h00 : sCnt_reg + 8'h01;
            if (sWrap) begin
                sHalf_next = ~sHalf_reg;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_reg <= '0;
            sCnt_reg  <= 8'h00;
            sHalf_reg <= 1'b0;
        end else if (sysClkEn) begin
            presc_reg <= presc_next;
            sCnt_reg  <= sCnt_next;
            sHalf_reg <= sHalf_next;
        end
    end

    // Register file: decode, write and read
    always_comb begin
        ack_next    = (avsRead | avsWrite) & ~ack_reg;
        rdata_next  = rdata_reg;
        clkSel_next = clkSel_reg;
        srcLvl_next = srcLvl_reg;
        scale_next  = scale_reg;
        enable_next = enable_reg;
        test_next   = test_reg;
        wrCnt       = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            per_next[i] = per_reg[i];
            dty_next[i] = dty_reg[i];
        end
        if (wrEn) begin
            if (idx == IDX_CLKSEL) clkSel_next = avsWritedata[7:0];
            if (idx == IDX_SRCLVL) srcLvl_next = avsWritedata[7:0];
            if (idx == IDX_SCALE)  scale_next  = avsWritedata[7:0];
            if (idx == IDX_ENABLE) enable_next = {4'h0, avsWritedata[3:0]};
            if (idx == IDX_TEST)   test_next   = {6'h00, avsWritedata[1:0]};
            for (int i = 0; i < NUM_CH; i++) begin
                if (idx == IDX_CNT0 + 14'(i)) wrCnt[i]    = 1'b1;
                if (idx == IDX_PER0 + 14'(i)) per_next[i] = avsWritedata[7:0];
                if (idx == IDX_DTY0 + 14'(i)) dty_next[i] = avsWritedata[7:0];
            end
        end
        if (rdEn) begin
            rdata_next = UNMAPPED_DATA;
            if (idx == IDX_CLKSEL) rdata_next[7:0] = clkSel_reg;
            if (idx == IDX_SRCLVL) rdata_next[7:0] = srcLvl_reg;
            if (idx == IDX_ENABLE) rdata_next[7:0] = enable_reg;
            if (idx == IDX_TEST)   rdata_next[7:0] = test_reg;
            if (idx == IDX_SCALE) begin
                if (test_reg[TEST_MODE_BIT] && test_reg[TEST_READ_BIT]) begin
                    rdata_next[7:0] = sCnt_reg;
                end else begin
                    rdata_next[7:0] = scale_reg;
                end
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (idx == IDX_CNT0 + 14'(i)) rdata_next[7:0] = cnt_reg[i];
                if (idx == IDX_PER0 + 14'(i)) rdata_next[7:0] = per_reg[i];
                if (idx == IDX_DTY0 + 14'(i)) rdata_next[7:0] = dty_reg[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg    <= 1'b0;
            rdata_reg  <= UNMAPPED_DATA;
            clkSel_reg <= RST_CTRL;
            srcLvl_reg <= RST_CTRL;
            scale_reg  <= RST_CTRL;
            enable_reg <= RST_CTRL;
            test_reg   <= RST_CTRL;
            for (int i = 0; i < NUM_CH; i++) begin
                per_reg[i] <= RST_PER_DTY;
                dty_reg[i] <= RST_PER_DTY;
            end
        end else if (sysClkEn) begin
            ack_reg    <= ack_next;
            rdata_reg  <= rdata_next;
            clkSel_reg <= clkSel_next;
            srcLvl_reg <= srcLvl_next;
            scale_reg  <= scale_next;
            enable_reg <= enable_next;
            test_reg   <= test_next;
            for (int i = 0; i < NUM_CH; i++) begin
                per_reg[i] <= per_next[i];
                dty_reg[i] <= dty_next[i];
            end
        end
    end

    // Channel pairs; the odd channel of a pair is the low byte when joined
    for (genvar p = 0; p < NUM_CH / 2; p++) begin : g_pair
        localparam int HI = 2 * p;
        localparam int LO = 2 * p + 1;
        logic        joined;
        logic [15:0] c16, p16, d16, c16Inc;
        assign joined = clkSel_reg[p == 0 ? CLK_JOIN_LOW : CLK_JOIN_HIGH];
        assign c16    = {cnt_reg[HI], cnt_reg[LO]};
        assign p16    = {perBuf_reg[HI], perBuf_reg[LO]};
        assign d16    = {dtyBuf_reg[HI], dtyBuf_reg[LO]};
        assign c16Inc = c16 + 16'h0001;

        always_comb begin
            logic [7:0] inc;
            inc = 8'h00;
            for (int k = HI; k <= LO; k++) begin
                cnt_next[k]    = cnt_reg[k];
                perBuf_next[k] = perBuf_reg[k];
                dtyBuf_next[k] = dtyBuf_reg[k];
                // Enable takes hold only on a selected clock edge
                run_next[k] = chTick[k] ? enable_reg[k] : run_reg[k];
                wave_next[k] = (cnt_reg[k] < dtyBuf_reg[k]) ?
                               srcLvl_reg[SRC_LEVEL_LO + k] :
                               ~srcLvl_reg[SRC_LEVEL_LO + k];
            end
            if (joined) begin
                wave_next[LO] = (c16 < d16) ? srcLvl_reg[SRC_LEVEL_LO + LO] :
                                ~srcLvl_reg[SRC_LEVEL_LO + LO];
                wave_next[HI] = 1'b0;
                if (wrCnt[HI] || wrCnt[LO]) begin
                    cnt_next[HI] = RST_COUNT;
                    cnt_next[LO] = RST_COUNT;
                    perBuf_next[HI] = per_reg[HI];
                    perBuf_next[LO] = per_reg[LO];
                    dtyBuf_next[HI] = dty_reg[HI];
                    dtyBuf_next[LO] = dty_reg[LO];
                end else if (run_reg[LO] && chTick[LO]) begin
                    if (c16Inc >= p16) begin
                        cnt_next[HI]    = RST_COUNT;
                        cnt_next[LO]    = RST_COUNT;
                        perBuf_next[HI] = per_reg[HI];
                        perBuf_next[LO] = per_reg[LO];
                        dtyBuf_next[HI] = dty_reg[HI];
                        dtyBuf_next[LO] = dty_reg[LO];
                    end else begin
                        cnt_next[HI] = c16Inc[15:8];
                        cnt_next[LO] = c16Inc[7:0];
                    end
                end
            end else begin
                for (int k = HI; k <= LO; k++) begin
                    inc = cnt_reg[k] + 8'h01;
                    if (wrCnt[k]) begin
                        cnt_next[k]    = RST_COUNT;
                        perBuf_next[k] = per_reg[k];
                        dtyBuf_next[k] = dty_reg[k];
                    end else if (run_reg[k] && chTick[k]) begin
                        if (inc >= perBuf_reg[k]) begin
                            cnt_next[k]    = RST_COUNT;
                            perBuf_next[k] = per_reg[k];
                            dtyBuf_next[k] = dty_reg[k];
                        end else begin
                            cnt_next[k] = inc;
                        end
                    end
                end
            end
        end

        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                for (int k = HI; k <= LO; k++) begin
                    cnt_reg[k]    <= RST_COUNT;
                    perBuf_reg[k] <= RST_PER_DTY;
                    dtyBuf_reg[k] <= RST_PER_DTY;
                    run_reg[k]    <= 1'b0;
                    wave_reg[k]   <= 1'b0;
                end
            end else if (sysClkEn) begin
                for (int k = HI; k <= LO; k++) begin
                    cnt_reg[k]    <= cnt_next[k];
                    perBuf_reg[k] <= perBuf_next[k];
                    dtyBuf_reg[k] <= dtyBuf_next[k];
                    run_reg[k]    <= run_next[k];
                    wave_reg[k]   <= wave_next[k];
                end
            end
        end
    end

    // Pin mux; the direction input is only overridden, never changed
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            pinOe[i]  = enable_reg[i] | gpioDir[i];
            pinOut[i] = run_reg[i] ? wave_reg[i] : gpioData[i];
        end
    end
endmodule // pwc_core
`default_nettype wire

/* tb/pwc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module pwc_monitor (
    input wire logic                       sys_clk,
    input wire logic                       rst_b,
    input wire logic [pwc_pkg::ADDR_W-1:0] avsAddress,
    input wire logic                       avsRead,
    input wire logic                       avsWrite,
    input wire logic [31:0]                avsWritedata,
    input wire logic [3:0]                 avsByteenable,
    input wire logic [31:0]                avsReaddata,
    input wire logic                       avsWaitrequest,
    input wire logic [pwc_pkg::NUM_CH-1:0] gpioDir,
    input wire logic [pwc_pkg::NUM_CH-1:0] pinOe
);
    import pwc_pkg::*;
    logic [3:0]  enShadow_reg;
    logic [3:0]  enShadow_next;
    logic [13:0] idx;
    logic        rdDone;
    assign idx = avsAddress[15:2];
    assign rdDone = avsRead && !avsWaitrequest;
    // Shadow of the enable bits, taken at the completion edge of each enable write with byte lane 0 set
    always_comb begin
        enShadow_next = enShadow_reg;
        if (avsWrite && !avsWaitrequest && avsByteenable[0] && idx == IDX_ENABLE) begin
            enShadow_next = avsWritedata[3:0];
        end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            enShadow_reg <= 4'h0;
        end else begin
            enShadow_reg <= enShadow_next;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence oneWait_s;
        avsWaitrequest ##1 !avsWaitrequest;
    endsequence
    wr_wait_a: assert property ($rose(avsWrite) |-> oneWait_s)
        else $error("write not answered after one wait state");
    rd_wait_a: assert property ($rose(avsRead) |-> oneWait_s)
        else $error("read not answered after one wait state");
    idle_nowait_a: assert property (!(avsRead || avsWrite) |-> !avsWaitrequest)
        else $error("wait raised with no request");
    pin_oe_a: assert property (pinOe == (enShadow_reg | gpioDir))
        else $error("pin enable differs from enable or direction");
    rd_enable_a: assert property (rdDone && idx == IDX_ENABLE |-> avsReaddata[3:0] == enShadow_reg)
        else $error("enable readback wrong");
    unmapped_zero_a: assert property (rdDone && (idx < IDX_CLKSEL || idx > IDX_TEST)
        |-> avsReaddata == UNMAPPED_DATA)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (avsReaddata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    rd_stable_a: assert property (!avsRead |=> $stable(avsReaddata))
        else $error("read data changed without a read");
endmodule // pwc_monitor
`default_nettype wire

/* tb/pwc_core_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pwc_core_tb;
    import pwc_pkg::*;
    logic        sys_clk       = 1'b0;
    logic        rst_b         = 1'b0;
    logic        sysClkEn      = 1'b1;
    logic [15:0] avsAddress    = 16'h0000;
    logic        avsRead       = 1'b0;
    logic        avsWrite      = 1'b0;
    logic [31:0] avsWritedata  = 32'h0000_0000;
    logic [3:0]  avsByteenable = 4'h0;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic [3:0]  gpioData      = 4'h0;
    logic [3:0]  gpioDir       = 4'h0;
    logic [3:0]  pinOut;
    logic [3:0]  pinOe;
    logic [31:0] q;
    int          n_errors      = 0;
    int          cmp_count     = 0;
    always #5 sys_clk = ~sys_clk;
    pwc_core i_pwc_core (.sys_clk(sys_clk), .rst_b(rst_b), .sysClkEn(sysClkEn),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .gpioData(gpioData), .gpioDir(gpioDir), .pinOut(pinOut), .pinOe(pinOe));
    task automatic results();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Waitrequest and read data are taken at the rising edge, before that edge's updates land
    task automatic bus(input logic we, input logic [13:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        logic w;
        int   n;
        n = 0;
        avsAddress <= {idx, 2'b00};
        avsWritedata <= {24'h00_0000, d};
        avsByteenable <= be;
        avsWrite <= we;
        avsRead <= !we;
        do begin
            @(posedge sys_clk);
            w = avsWaitrequest;
            q = avsReaddata;
            n++;
        end while (w !== 1'b0 && n < 50);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        chk(w, 1'b0, "bus answer");
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask
    task automatic rd(input logic [13:0] idx);
        bus(1'b0, idx, 8'h00, 4'h1);
    endtask
    task automatic setup(input logic [13:0] c, input logic [7:0] per, input logic [7:0] dty);
        wr(IDX_PER0 + c, per);
        wr(IDX_DTY0 + c, dty);
        wr(IDX_CNT0 + c, 8'h00);
    endtask
    // The output is run on to its second rising edge so a clock change or buffer load has settled
    task automatic pwm(input int ch, input int p, input int dd, input int t, input logic lvl);
        int hi;
        int lo;
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        repeat (2) begin
            while (pinOut[ch] !== 1'b0 && n < 8000) begin @(negedge sys_clk); n++; end
            while (pinOut[ch] !== 1'b1 && n < 8000) begin @(negedge sys_clk); n++; end
        end
        while (pinOut[ch] === 1'b1 && n < 8000) begin @(negedge sys_clk); hi++; n++; end
        while (pinOut[ch] === 1'b0 && n < 8000) begin @(negedge sys_clk); lo++; n++; end
        @(posedge sys_clk);
        chk(hi, lvl ? dd * t : (p - dd) * t, "high time");
        chk(lo, lvl ? (p - dd) * t : dd * t, "low time");
    endtask
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            rd(IDX_CLKSEL + i[13:0]);
            chk(q, RST_CTRL, "reset value");
        end
        rd(IDX_PER0);
        chk(q, RST_PER_DTY, "period reset");
    endtask
    task automatic t_regs();
        for (int i = 0; i < 3; i++) begin
            wr(IDX_CLKSEL + i[13:0], 8'h5A);
            rd(IDX_CLKSEL + i[13:0]);
            chk(q, 32'h5A, "readback");
            wr(IDX_CLKSEL + i[13:0], 8'h00);
        end
        wr(IDX_ENABLE, 8'h0F);
        rd(IDX_ENABLE);
        chk(q, 32'h0F, "enable readback");
        wr(IDX_ENABLE, 8'h00);
        bus(1'b1, IDX_SCALE, 8'h33, 4'h0);
        rd(IDX_SCALE);
        chk(q, 32'h00, "masked write");
        wr(14'h1080, 8'hFF);
        rd(14'h1080);
        chk(q, UNMAPPED_DATA, "unmapped read");
    endtask
    task automatic t_rate_a();
        setup(14'h0000, 8'h04, 8'h01);
        wr(IDX_SRCLVL, 8'h01);
        wr(IDX_ENABLE, 8'h01);
        for (int r = 0; r < 4; r++) begin
            wr(IDX_CLKSEL, r[7:0]);
            pwm(0, 4, 1, 1 << r, 1'b1);
        end
        wr(IDX_ENABLE, 8'h00);
    endtask
    // Clock A is left at its slowest rate so a wrong source shows up
    task automatic t_rate_b();
        setup(14'h0002, 8'h02, 8'h01);
        wr(IDX_SRCLVL, 8'h04);
        wr(IDX_ENABLE, 8'h04);
        for (int r = 0; r < 8; r++) begin
            wr(IDX_CLKSEL, {2'b00, r[2:0], 3'b011});
            pwm(2, 2, 1, 1 << r, 1'b1);
        end
        wr(IDX_ENABLE, 8'h00);
    endtask
    task automatic t_scaled();
        wr(IDX_CLKSEL, 8'h39);
        wr(IDX_SCALE, 8'h03);
        setup(14'h0000, 8'h04, 8'h01);
        setup(14'h0003, 8'h02, 8'h01);
        wr(IDX_SRCLVL, 8'h98);
        wr(IDX_ENABLE, 8'h09);
        pwm(0, 4, 1, 12, 1'b0);
        pwm(3, 2, 1, 12, 1'b1);
        wr(IDX_CLKSEL, 8'h00);
        wr(IDX_SCALE, 8'h00);
        pwm(3, 2, 1, 512, 1'b1);
        wr(IDX_ENABLE, 8'h00);
    endtask
    task automatic t_test();
        logic [31:0] a;
        wr(IDX_TEST, 8'h03);
        wr(IDX_SCALE, 8'h40);
        rd(IDX_SCALE);
        a = q;
        // A low clock enable must freeze the counter; only three enabled edges pass
        sysClkEn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        sysClkEn <= 1'b1;
        rd(IDX_SCALE);
        chk(q, a + 32'h0000_0003, "frozen scaled counter");
        cmp_count++;
        if (!(a[7:0] < 8'h10) || a === q) begin
            n_errors++;
            $display("MISMATCH %0t scaled counter read %h then %h", $time, a, q);
        end
        wr(IDX_TEST, 8'h00);
        rd(IDX_SCALE);
        chk(q, 32'h40, "scale stored");
    endtask
    task automatic t_duty();
        logic [1:0] seen;
        wr(IDX_SRCLVL, 8'h01);
        wr(IDX_ENABLE, 8'h01);
        for (int k = 0; k < 2; k++) begin
            setup(14'h0000, 8'h04, k ? 8'h00 : 8'h04);
            seen = 2'b00;
            repeat (12) @(posedge sys_clk);
            repeat (20) begin @(negedge sys_clk); seen |= pinOut[0] ? 2'b10 : 2'b01; end
            @(posedge sys_clk);
            chk(seen, k ? 2'b01 : 2'b10, "flat level");
        end
        wr(IDX_ENABLE, 8'h00);
    endtask
    // Period 0x0100 and duty 0x0040 only come out right with the byte order kept
    task automatic t_join();
        wr(IDX_CLKSEL, 8'h40);
        setup(14'h0000, 8'h01, 8'h00);
        setup(14'h0001, 8'h00, 8'h40);
        wr(IDX_SRCLVL, 8'h02);
        wr(IDX_ENABLE, 8'h02);
        pwm(1, 256, 64, 1, 1'b1);
        wr(IDX_ENABLE, 8'h00);
        wr(IDX_CLKSEL, 8'h00);
    endtask
    task automatic t_pins();
        gpioDir <= 4'h5;
        gpioData <= 4'hA;
        wr(IDX_ENABLE, 8'h02);
        @(negedge sys_clk);
        chk(pinOe, 4'h7, "forced output");
        @(posedge sys_clk);
        wr(IDX_ENABLE, 8'h00);
        repeat (4) @(negedge sys_clk);
        chk(pinOe, 4'h5, "direction back");
        chk(pinOut, 4'hA, "port value back");
        @(posedge sys_clk);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_regs();
        t_rate_a();
        t_rate_b();
        t_scaled();
        t_test();
        t_duty();
        t_join();
        t_pins();
        results();
    end
    // Whole run is under 8k cycles; this allows 100k, over twelve times that
    initial begin
        #1000000;
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end
endmodule // pwc_core_tb
bind pwc_core pwc_monitor i_pwc_monitor (.sys_clk(sys_clk), .rst_b(rst_b),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .gpioDir(gpioDir), .pinOe(pinOe));
`default_nettype wire
